// file: core/sdif_defs.vh
// sdif_defs.vh: constants for the servo drive input function decoder
// assumes: included by bare name from core design files
`ifndef SDIF_DEFS_VH
`define SDIF_DEFS_VH
// number of physical input slots
`define SDIF_SLOTS 6
// index of the two fixed slots (third and fourth slot)
`define SDIF_SLOT_CLEAR 2
`define SDIF_SLOT_INHIBIT 3
// function codes held in a slot selector
`define SDIF_FN_W 4
`define SDIF_FN_NONE 4'h0
`define SDIF_FN_SERVO_ENABLE_IN 4'h1
`define SDIF_FN_ALM_CLR 4'h2
`define SDIF_FN_DEV_CLR 4'h3
`define SDIF_FN_INHIBIT 4'h4
`define SDIF_FN_NEG_LIM 4'h5
`define SDIF_FN_POS_LIM 4'h6
`define SDIF_FN_SCALE_A 4'h7
`define SDIF_FN_DAMP_A 4'h8
`define SDIF_FN_GAIN 4'h9
`define SDIF_FN_TLIM 4'ha
`define SDIF_FN_DAMP_B 4'hb
`define SDIF_FN_SCALE_B 4'hc
`define SDIF_FN_FORCE 4'hd
// slot selector: function code plus polarity bit (1 = active low)
`define SDIF_SEL_W 5
`define SDIF_SEL_POL 4
// default slot assignments, slots one to six
`define SDIF_SEL_RESET0 5'h01
`define SDIF_SEL_RESET1 5'h02
`define SDIF_SEL_RESET2 5'h03
`define SDIF_SEL_RESET3 5'h04
`define SDIF_SEL_RESET4 5'h05
`define SDIF_SEL_RESET5 5'h06
// register indices, address is a word index
`define SDIF_AW 4
`define SDIF_REG_SEL0 4'h0
`define SDIF_REG_TRAVEL 4'h6
`define SDIF_REG_CLRMODE 4'h7
`define SDIF_REG_INHINV 4'h8
`define SDIF_REG_PULSE_EN 4'h9
`define SDIF_REG_STATUS 4'ha
`define SDIF_REG_MASK 4'hb
`define SDIF_REG_IRQ 4'hc
// travel inhibit setup values
`define SDIF_TRAVEL_W 2
`define SDIF_TRAVEL_RESET 2'h1
`define SDIF_TRAVEL_OFF 2'h1
// counter clear modes
`define SDIF_CLRMODE_W 2
`define SDIF_CLRMODE_RESET 2'h0
`define SDIF_CLRMODE_LEVEL 2'h1
`define SDIF_CLRMODE_RISE 2'h0
`define SDIF_CLRMODE_FALL 2'h2
// inhibit invalidation: only zero lets the inhibit act
`define SDIF_INHINV_RESET 1'h1
`define SDIF_INHINV_ACTIVE 1'h0
// interrupt event bits
`define SDIF_EV_W 4
`define SDIF_EV_FORCE 0
`define SDIF_EV_POS 1
`define SDIF_EV_NEG 2
`define SDIF_EV_DEVCLR 3
`endif

// file: core/sdif_input_decoder.v
// sdif_input_decoder.v: servo drive control input function decoder
// assumes: inputs synchronous to ref_clk, register port one-cycle strobes
// assumes: the host reaches selectors by word index and never waits
// assumes: slot levels are raw contact states, polarity is applied here
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "sdif_defs.vh"
`default_nettype none

module sdif_input_decoder #(
  parameter SLOTS = `SDIF_SLOTS
) (
  input wire ref_clk,
  input wire resetn,
  input wire [SLOTS-1:0] slot_in,
  input wire cmd_pulse_in_p,
  input wire cmd_pulse_in_n,
  input wire cmd_direction_in_p,
  input wire cmd_direction_in_n,
  input wire alarm_unclearable,
  input wire [`SDIF_AW-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  output reg servo_enable_q,
  output reg pos_stop_q,
  output reg neg_stop_q,
  output reg deviation_clear_q,
  output reg alarm_clear_q,
  output reg pulse_inhibit_q,
  output reg cmd_pulse_q,
  output reg cmd_direction_q,
  output reg [1:0] damping_sel_q,
  output reg gain_sel_q,
  output reg torque_limit_select_q,
  output reg scaling_select_a_q,
  output reg scaling_select_b_q,
  output reg forced_alarm_error_q,
  output reg irq_q
);

  // look up the active state of one function among all slots
  function fn_active;
    input [SLOTS*`SDIF_SEL_W-1:0] sels;
    input [SLOTS-1:0] lvl;
    input [`SDIF_FN_W-1:0] code;
    integer k;
    reg [`SDIF_SEL_W-1:0] s;
    begin
      fn_active = 1'b0;
      for (k = 0; k < SLOTS; k = k + 1) begin
        s = sels[k*`SDIF_SEL_W +: `SDIF_SEL_W];
        if (s[`SDIF_FN_W-1:0] == code)
          fn_active = fn_active | (lvl[k] ^ s[`SDIF_SEL_POL]);
      end
    end
  endfunction

  // register index match, shared by every register write decode
  function addr_is;
    input [`SDIF_AW-1:0] a;
    input [`SDIF_AW-1:0] idx;
    begin
      addr_is = (a == idx);
    end
  endfunction

  // two-stage synchronisers for slots and pulse pair
  // only the second stage is read, so a metastable first stage has no fanout
  reg [SLOTS-1:0] slot_s1_q;
  reg [SLOTS-1:0] slot_s2_q;
  reg [3:0] pair_s1_q;
  reg [3:0] pair_s2_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slot_s1_q <= {SLOTS{1'b0}};
      slot_s2_q <= {SLOTS{1'b0}};
      pair_s1_q <= 4'h0;
      pair_s2_q <= 4'h0;
    end else begin
      slot_s1_q <= slot_in;
      slot_s2_q <= slot_s1_q;
      pair_s1_q <= {cmd_direction_in_n, cmd_direction_in_p,
                    cmd_pulse_in_n, cmd_pulse_in_p};
      pair_s2_q <= pair_s1_q;
    end
  end

  // configuration registers
  wire [SLOTS*`SDIF_SEL_W-1:0] sel_q;
  reg [`SDIF_TRAVEL_W-1:0] travel_q;
  reg [`SDIF_CLRMODE_W-1:0] clrmode_q;
  reg inhinv_q;
  reg pulse_en_q;
  reg [`SDIF_EV_W-1:0] status_q;
  reg [`SDIF_EV_W-1:0] mask_q;
  // selector defaults: slots one to six carry functions one to six
  localparam [SLOTS*`SDIF_SEL_W-1:0] SEL_RESET = {`SDIF_SEL_RESET5,
    `SDIF_SEL_RESET4, `SDIF_SEL_RESET3, `SDIF_SEL_RESET2, `SDIF_SEL_RESET1,
    `SDIF_SEL_RESET0};

  // slot selector writes; fixed slots keep their function code
  // each slot owns its selector flops, so every flop has a single driver
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : g_sel
      localparam [`SDIF_AW-1:0] IDX = g;
      reg [`SDIF_SEL_W-1:0] slot_sel_q;
      wire hit;
      wire fixed;
      assign hit = reg_wr && addr_is(reg_addr, `SDIF_REG_SEL0 + IDX);
      assign fixed = (g == `SDIF_SLOT_CLEAR) || (g == `SDIF_SLOT_INHIBIT);
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          slot_sel_q <= SEL_RESET[g*`SDIF_SEL_W +: `SDIF_SEL_W];
        end else if (hit && fixed) begin
          // only polarity may change on the fixed slots
          slot_sel_q[`SDIF_SEL_POL] <= reg_wdata[`SDIF_SEL_POL];
        end else if (hit) begin
          slot_sel_q <= reg_wdata[`SDIF_SEL_W-1:0];
        end
      end
      assign sel_q[g*`SDIF_SEL_W +: `SDIF_SEL_W] = slot_sel_q;
    end
  endgenerate

  // decoded function levels
  wire f_srv;
  wire f_aclr;
  wire f_clr;
  wire f_inh;
  wire f_neg;
  wire f_pos;
  wire f_scale_a;
  wire f_damp_a;
  wire f_gain;
  wire f_tlim;
  wire f_damp_b;
  wire f_scale_b;
  wire f_force;
  // unassigned functions find no slot and read inactive
  // a slot with its polarity bit set reads its contact as active low
  assign f_srv = fn_active(sel_q, slot_s2_q, `SDIF_FN_SERVO_ENABLE_IN);
  assign f_aclr = fn_active(sel_q, slot_s2_q, `SDIF_FN_ALM_CLR);
  assign f_clr = fn_active(sel_q, slot_s2_q, `SDIF_FN_DEV_CLR);
  assign f_inh = fn_active(sel_q, slot_s2_q, `SDIF_FN_INHIBIT);
  assign f_neg = fn_active(sel_q, slot_s2_q, `SDIF_FN_NEG_LIM);
  assign f_pos = fn_active(sel_q, slot_s2_q, `SDIF_FN_POS_LIM);
  assign f_scale_a = fn_active(sel_q, slot_s2_q, `SDIF_FN_SCALE_A);
  assign f_damp_a = fn_active(sel_q, slot_s2_q, `SDIF_FN_DAMP_A);
  assign f_gain = fn_active(sel_q, slot_s2_q, `SDIF_FN_GAIN);
  assign f_tlim = fn_active(sel_q, slot_s2_q, `SDIF_FN_TLIM);
  assign f_damp_b = fn_active(sel_q, slot_s2_q, `SDIF_FN_DAMP_B);
  assign f_scale_b = fn_active(sel_q, slot_s2_q, `SDIF_FN_SCALE_B);
  assign f_force = fn_active(sel_q, slot_s2_q, `SDIF_FN_FORCE);

  // edge detection on deviation clear and alarm clear
  // history flops reset to the idle level, so no false edge follows reset
  reg clr_prev_q;
  reg aclr_prev_q;
  reg clr_pulse_d;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clr_prev_q <= 1'b0;
      aclr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= f_clr;
      aclr_prev_q <= f_aclr;
    end
  end

  // counter clear mode selects edge or level behaviour
  // a code outside the map behaves as the rising-edge default
  always @* begin
    case (clrmode_q)
      `SDIF_CLRMODE_LEVEL: clr_pulse_d = f_clr;
      `SDIF_CLRMODE_FALL: clr_pulse_d = clr_prev_q & ~f_clr;
      `SDIF_CLRMODE_RISE: clr_pulse_d = f_clr & ~clr_prev_q;
      default: clr_pulse_d = f_clr & ~clr_prev_q;
    endcase
  end

  // limits and inhibit are qualified by their setup registers
  wire travel_on;
  wire inhibit_on;
  assign travel_on = (travel_q != `SDIF_TRAVEL_OFF);
  assign inhibit_on = f_inh && (inhinv_q == `SDIF_INHINV_ACTIVE);

  // enable and overtravel stops, registered
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      servo_enable_q <= 1'b0;
      pos_stop_q <= 1'b0;
      neg_stop_q <= 1'b0;
    end else begin
      servo_enable_q <= f_srv;
      pos_stop_q <= travel_on & f_pos;
      neg_stop_q <= travel_on & f_neg;
    end
  end

  // clear requests: deviation clear per mode, alarm clear on rising edge
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      deviation_clear_q <= 1'b0;
      alarm_clear_q <= 1'b0;
    end else begin
      deviation_clear_q <= clr_pulse_d;
      // blocked while an alarm is present that this input cannot clear
      alarm_clear_q <= f_aclr & ~aclr_prev_q & ~alarm_unclearable;
    end
  end

  // pulse inhibit and the gated line-driver pair
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_inhibit_q <= 1'b0;
      cmd_pulse_q <= 1'b0;
      cmd_direction_q <= 1'b0;
    end else begin
      pulse_inhibit_q <= inhibit_on;
      // pulse passes only when enabled and not inhibited; direction needs only the enable
      cmd_pulse_q <= pulse_en_q & ~inhibit_on &
                     (pair_s2_q[0] & ~pair_s2_q[1]);
      cmd_direction_q <= pulse_en_q &
                         (pair_s2_q[2] & ~pair_s2_q[3]);
    end
  end

  // loop selections and the forced alarm
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      damping_sel_q <= 2'h0;
      gain_sel_q <= 1'b0;
      torque_limit_select_q <= 1'b0;
      scaling_select_a_q <= 1'b0;
      scaling_select_b_q <= 1'b0;
      forced_alarm_error_q <= 1'b0;
    end else begin
      damping_sel_q <= {f_damp_b, f_damp_a};
      gain_sel_q <= f_gain;
      torque_limit_select_q <= f_tlim;
      scaling_select_a_q <= f_scale_a;
      scaling_select_b_q <= f_scale_b;
      forced_alarm_error_q <= f_force;
    end
  end

  // events for the sticky status register
  // force and limit events mark the first cycle of their condition; the deviation clear event is clr_pulse_d, a level in level mode
  wire [`SDIF_EV_W-1:0] ev;
  assign ev[`SDIF_EV_FORCE] = f_force & ~forced_alarm_error_q;
  assign ev[`SDIF_EV_POS] = travel_on & f_pos & ~pos_stop_q;
  assign ev[`SDIF_EV_NEG] = travel_on & f_neg & ~neg_stop_q;
  assign ev[`SDIF_EV_DEVCLR] = clr_pulse_d;

  // write-one-to-clear strobe and the next status value
  wire wr_status;
  wire [`SDIF_EV_W-1:0] status_clr;
  wire [`SDIF_EV_W-1:0] status_d;
  assign wr_status = reg_wr && addr_is(reg_addr, `SDIF_REG_STATUS);
  assign status_clr = wr_status ? reg_wdata[`SDIF_EV_W-1:0] :
                      {`SDIF_EV_W{1'b0}};
  // an event in the same cycle as its clear keeps the bit set
  assign status_d = (status_q & ~status_clr) | ev;

  // travel inhibit setup; the reset value leaves both limits unused
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      travel_q <= `SDIF_TRAVEL_RESET;
    else if (reg_wr && addr_is(reg_addr, `SDIF_REG_TRAVEL))
      travel_q <= reg_wdata[`SDIF_TRAVEL_W-1:0];
  end

  // counter clear mode; reset selects the rising-edge clear
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      clrmode_q <= `SDIF_CLRMODE_RESET;
    else if (reg_wr && addr_is(reg_addr, `SDIF_REG_CLRMODE))
      clrmode_q <= reg_wdata[`SDIF_CLRMODE_W-1:0];
  end

  // inhibit invalidation; the inhibit acts only while this holds zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      inhinv_q <= `SDIF_INHINV_RESET;
    else if (reg_wr && addr_is(reg_addr, `SDIF_REG_INHINV))
      inhinv_q <= reg_wdata[0];
  end

  // line-driver pair enable; the pair is ignored until software sets it
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      pulse_en_q <= 1'b0;
    else if (reg_wr && addr_is(reg_addr, `SDIF_REG_PULSE_EN))
      pulse_en_q <= reg_wdata[0];
  end

  // interrupt mask, one bit per status event
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      mask_q <= {`SDIF_EV_W{1'b0}};
    else if (reg_wr && addr_is(reg_addr, `SDIF_REG_MASK))
      mask_q <= reg_wdata[`SDIF_EV_W-1:0];
  end

  // sticky status: set by events, cleared by writing ones
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      status_q <= {`SDIF_EV_W{1'b0}};
    else
      status_q <= status_d;
  end

  // level interrupt from the next status, so it moves with status_q
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_d & mask_q);
  end

  // read data one cycle after the read strobe, zero elsewhere
  // selector reads let software confirm the codes of the fixed slots
  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    if (reg_addr < `SDIF_REG_SEL0 + SLOTS)
      rd_d[`SDIF_SEL_W-1:0] = sel_q[reg_addr*`SDIF_SEL_W +: `SDIF_SEL_W];
    else begin
      case (reg_addr)
        `SDIF_REG_TRAVEL: rd_d[`SDIF_TRAVEL_W-1:0] = travel_q;
        `SDIF_REG_CLRMODE: rd_d[`SDIF_CLRMODE_W-1:0] = clrmode_q;
        `SDIF_REG_INHINV: rd_d[0] = inhinv_q;
        `SDIF_REG_PULSE_EN: rd_d[0] = pulse_en_q;
        `SDIF_REG_STATUS: rd_d[`SDIF_EV_W-1:0] = status_q;
        `SDIF_REG_MASK: rd_d[`SDIF_EV_W-1:0] = mask_q;
        `SDIF_REG_IRQ: rd_d = {2'h0, slot_s2_q[5:0]};
        default: rd_d = 8'h00;
      endcase
    end
  end

  // read data register, zero whenever no read was strobed
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_d;
    else
      reg_rdata_q <= 8'h00;
  end

endmodule // sdif_input_decoder
`default_nettype wire

// file: bench/sdif_properties.sv
// sdif_properties.sv: port assertions for the input decoder
// assumes: slots one to five keep their default function and polarity
`timescale 1ns/1ns
`default_nettype none
module sdif_properties #(parameter SLOTS = 6) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [SLOTS-1:0] slot_in,
  input wire logic cmd_pulse_in_p,
  input wire logic cmd_pulse_in_n,
  input wire logic alarm_unclearable,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic servo_enable_q,
  input wire logic neg_stop_q,
  input wire logic deviation_clear_q,
  input wire logic alarm_clear_q,
  input wire logic pulse_inhibit_q,
  input wire logic cmd_pulse_q,
  input wire logic irq_q
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // levels follow the pin three edges later
  a_servo_follows: assert property (
    servo_enable_q == $past(slot_in[0], 3)) else $error("servo enable wrong");
  a_alarm_single: assert property (
    alarm_clear_q |=> !alarm_clear_q) else $error("alarm clear too long");
  a_alarm_cause: assert property (
    alarm_clear_q |-> $past(slot_in[1], 3) && !$past(slot_in[1], 4))
    else $error("alarm clear without rising input");
  a_alarm_held: assert property (
    alarm_unclearable [*4] |=> !alarm_clear_q)
    else $error("alarm clear while unclearable");
  a_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_q == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (
    $past(reg_rd) && $past(reg_addr) > 4'hc |-> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_pulse_cause: assert property (
    cmd_pulse_q |-> $past(cmd_pulse_in_p, 3) && !$past(cmd_pulse_in_n, 3))
    else $error("pulse without pair input");
  a_inhibit_level: assert property (
    pulse_inhibit_q |-> $past(slot_in[3], 3)) else $error("inhibit wrong");
  a_neg_cause: assert property (
    neg_stop_q |-> $past(slot_in[4], 3)) else $error("negative stop wrong");
  a_clear_cause: assert property (
    deviation_clear_q |-> $past(slot_in[2], 3) || $past(slot_in[2], 4))
    else $error("deviation clear without cause");
  // main scenarios reached
  c_alarm: cover property (alarm_clear_q);
  c_clear: cover property (deviation_clear_q);
  c_irq: cover property (irq_q);
endmodule // sdif_properties
bind sdif_input_decoder sdif_properties #(.SLOTS(SLOTS)) i_props (
  .ref_clk, .resetn, .slot_in, .cmd_pulse_in_p, .cmd_pulse_in_n,
  .alarm_unclearable, .reg_addr, .reg_rd, .reg_rdata_q, .servo_enable_q,
  .neg_stop_q, .deviation_clear_q, .alarm_clear_q, .pulse_inhibit_q,
  .cmd_pulse_q, .irq_q);
`default_nettype wire

// file: bench/sdif_plc_model.sv
// sdif_plc_model.sv: controller driving contacts and the pulse pair
// assumes: requests change just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module sdif_plc_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] slot_req,
  input wire logic pulse_req,
  input wire logic dir_req,
  output wire logic [5:0] slot_in,
  output wire logic cmd_pulse_in_p,
  output wire logic cmd_pulse_in_n,
  output wire logic cmd_direction_in_p,
  output wire logic cmd_direction_in_n
);
  logic [5:0] lvl_q = 6'h00;
  logic pul_q = 1'b0;
  logic dir_q = 1'b0;
  // contacts settle one edge after the decision
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_q <= 6'h00;
      pul_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      lvl_q <= slot_req;
      pul_q <= pulse_req;
      dir_q <= dir_req;
    end
  end
  // line driver pairs are always complementary
  assign slot_in = lvl_q;
  assign cmd_pulse_in_p = pul_q;
  assign cmd_pulse_in_n = ~pul_q;
  assign cmd_direction_in_p = dir_q;
  assign cmd_direction_in_n = ~dir_q;
endmodule // sdif_plc_model
`default_nettype wire

// file: bench/servo_drive_input_function_decoder_bench.sv
// bench for the input decoder: register port and slot levels
// assumes: sdif_defs.vh on the include path
`timescale 1ns/1ns
`include "sdif_defs.vh"
`default_nettype none
module servo_drive_input_function_decoder_bench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] slot_req = 6'h00;
  logic pulse_req = 1'b0;
  logic dir_req = 1'b0;
  logic alarm_unclearable = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic out_look = 1'b0;
  logic [15:0] exp_v, got_v;
  logic [15:0] notes[$];
  logic [13:0] fn_tab [0:6] = '{14'h0008, 14'h0040, 14'h0020, 14'h0010,
    14'h0080, 14'h0004, 14'h0002};
  int n_errors = 0;
  int total_checks = 0;
  int ph;
  wire [5:0] slot_in;
  wire [7:0] reg_rdata_q;
  wire [1:0] damping_sel_q;
  wire cmd_pulse_in_p, cmd_pulse_in_n, cmd_direction_in_p, cmd_direction_in_n;
  wire servo_enable_q, pos_stop_q, neg_stop_q, deviation_clear_q;
  wire alarm_clear_q, pulse_inhibit_q, cmd_pulse_q, cmd_direction_q;
  wire gain_sel_q, torque_limit_select_q, scaling_select_a_q;
  wire scaling_select_b_q, forced_alarm_error_q, irq_q;
  wire [13:0] outs = {servo_enable_q, pos_stop_q, neg_stop_q, pulse_inhibit_q,
    cmd_pulse_q, cmd_direction_q, damping_sel_q, gain_sel_q,
    torque_limit_select_q, scaling_select_a_q, scaling_select_b_q,
    forced_alarm_error_q, irq_q};
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  sdif_plc_model i_plc (.ref_clk, .resetn, .slot_req, .pulse_req, .dir_req,
    .slot_in, .cmd_pulse_in_p, .cmd_pulse_in_n, .cmd_direction_in_p,
    .cmd_direction_in_n);
  sdif_input_decoder i_dut (.ref_clk, .resetn, .slot_in, .cmd_pulse_in_p,
    .cmd_pulse_in_n, .cmd_direction_in_p, .cmd_direction_in_n,
    .alarm_unclearable, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .servo_enable_q, .pos_stop_q, .neg_stop_q, .deviation_clear_q,
    .alarm_clear_q, .pulse_inhibit_q, .cmd_pulse_q, .cmd_direction_q,
    .damping_sel_q, .gain_sel_q, .torque_limit_select_q, .scaling_select_a_q,
    .scaling_select_b_q, .forced_alarm_error_q, .irq_q);
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one-cycle bus strobes; a read notes its expectation first, a write notes none
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back({8'h00, e});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic look(input logic [13:0] e);
    @(posedge ref_clk);
    notes.push_back({2'b00, e});
    out_look <= 1'b1;
    @(posedge ref_clk);
    out_look <= 1'b0;
  endtask
  // expected output levels for random contacts in one setup phase
  function automatic logic [13:0] lvl(input int p, input logic [5:0] s,
    input logic pu, input logic di);
    lvl = {s[0], p != 0 && s[5], p != 0 && s[4], p != 0 && s[3],
      p != 0 && pu && !s[3], p != 0 && di, 8'h00};
  endfunction
  // monitor: takes the oldest note whenever a result stands
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_seen || out_look) begin
      exp_v = notes.pop_front();
      got_v = rd_seen ? {8'h00, reg_rdata_q} : {2'b00, outs};
      total_checks++;
      if (got_v !== exp_v) begin
        n_errors++;
        $display("BAD t=%0t exp=%h got=%h", $time, exp_v, got_v);
      end
    end
  end
  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    finish_test;
  end
  // main sequence
  initial begin
    void'($urandom(32'h1796));
    cyc(3);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], (i < 6) ? 8'(i + 1) : {7'h00, i == 6 || i == 8});
    end
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h03);
    for (ph = 0; ph < 3; ph++) begin
      if (ph != 0) begin
        wr(`SDIF_REG_TRAVEL, 8'h00);
        wr(`SDIF_REG_INHINV, 8'h00);
        wr(`SDIF_REG_PULSE_EN, 8'h01);
        wr(`SDIF_REG_CLRMODE, ph[7:0]);
      end
      repeat (8) begin
        slot_req <= 6'($urandom);
        pulse_req <= 1'($urandom);
        dir_req <= 1'($urandom);
        alarm_unclearable <= 1'($urandom);
        cyc(6);
        look(lvl(ph, slot_req, pulse_req, dir_req));
      end
    end
    slot_req <= 6'h00;
    pulse_req <= 1'b0;
    dir_req <= 1'b0;
    for (int c = 7; c < 14; c++) begin
      wr(4'h5, 8'h10 | c[7:0]);
      cyc(6);
      look(fn_tab[c-7]);
    end
    wr(4'h4, 8'h18);
    wr(4'h5, 8'h1b);
    cyc(6);
    look(14'h00c0);
    wr(4'h5, 8'h0d);
    cyc(6);
    wr(`SDIF_REG_STATUS, 8'h0f);
    rd(`SDIF_REG_STATUS, 8'h00);
    wr(`SDIF_REG_MASK, 8'h01);
    slot_req <= 6'h20;
    cyc(6);
    rd(`SDIF_REG_STATUS, 8'h01);
    look(14'h0043);
    slot_req <= 6'h00;
    cyc(6);
    wr(`SDIF_REG_MASK, 8'h00);
    cyc(2);
    look(14'h0040);
    wr(`SDIF_REG_STATUS, 8'h01);
    rd(`SDIF_REG_STATUS, 8'h00);
    finish_test;
  end
endmodule // servo_drive_input_function_decoder_bench
`default_nettype wire
